// ---- hw/adc_power_sync_ref_config.sv ----
// Configuration bank: output drivers, power down mask, sync and reference selection
//
// Contract
// - Each set disable bit turns its driver off.
// - Data clock buffers follow their own controls.
// - Disable bits map to pins by mode.
// - Clock mask bit keeps clock buffer powered unless single ended clock is selected.
// - Amp mask bit keeps reference amplifier powered.
// - Bandgap bit set powers bandgap down.
// - Bandgap off lengthens wake up time.
// - Pin role bit picks power down or sync.
// - Register sync bit rise issues sync when sync enable is set.
// - Sync source bit selects register over pin.
// - Control source bit picks strap or register.
// - Reference field honoured only under register control.
// - Single ended clock bit needs register control.
// - Global power down applies mask settings.
// - Input type bits make channels single ended.
module adc_power_sync_ref_config
  import cfg_pkg::*;
#(
  parameter int WAKE_FAST_CYCLES = 16,
  parameter int WAKE_SLOW_CYCLES = 128,
  parameter int WAKE_W = 8
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic spi_sen_n, // Serial enable, active low
  input wire logic spi_sclk, // Serial clock, sampled
  input wire logic spi_sdata, // Serial data in
  output logic spi_sdout_q, // Serial data out
  input wire logic sync_or_powerdown_pin, // Shared sync or power down pin
  input wire logic reference_buffer_strap_pin, // Reference strap
  input wire logic global_powerdown_request, // Power control request
  input wire logic serial_mode, // Output interface is serial
  input wire logic external_data_clock_input_enable_a, // Data clock input enable, first
  input wire logic external_data_clock_input_enable_b, // Data clock input enable, second
  input wire logic data_clock_output_off_ctl, // Data clock driver off
  output logic [23:0] output_driver_off_bits_q, // Per-driver off
  output logic frame_clock_output_off_q, // Frame clock driver off
  output logic chan_a_bit1_off_q, // Channel A bit 1 driver off
  output logic chan_a_bit6_off_q, // Channel A bit 6 driver off
  output logic external_data_clock_input_on_q, // Data clock input buffer on
  output logic data_clock_output_off_q, // Data clock driver off
  output logic global_powerdown_q, // Global power down active
  output power_state_t power_q, // Analog block power downs
  output ref_cfg_t ref_q, // Effective reference choice
  output logic chan_a_single_ended_input_q, // Channel A single ended
  output logic chan_b_single_ended_input_q, // Channel B single ended
  output logic sync_pulse_q, // One-cycle sync command
  output logic analog_ready_q // Analog awake after power down
);

  localparam logic [WAKE_W-1:0] WAKE_FAST = WAKE_W'(WAKE_FAST_CYCLES);
  localparam logic [WAKE_W-1:0] WAKE_SLOW = WAKE_W'(WAKE_SLOW_CYCLES);
  localparam logic [WAKE_W-1:0] WAKE_ZERO = '0;

  spi_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] shift_q, shift_d;
  logic [7:0] out_q, out_d;
  logic sclk_q, sdout_d;
  logic [7:0] drv0_q, drv1_q, drv2_q, mask_q, syncref_q, intype_q;
  logic [7:0] drv0_d, drv1_d, drv2_d, mask_d, syncref_d, intype_d;
  logic wr_commit;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic pin_q, reg_sync_evt, pin_sync_evt, pin_pd, gpd;
  logic bg_was_off_q, bg_was_off_d;
  logic [WAKE_W-1:0] wake_q, wake_d;
  logic [23:0] drv_all;
  power_state_t power_d;
  ref_cfg_t ref_d;

  // Read decode, shared by the read path
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    unique case (a)
      ADDR_DRV_OFF_0: read_reg = drv0_q;
      ADDR_DRV_OFF_1: read_reg = drv1_q;
      ADDR_DRV_OFF_2: read_reg = drv2_q;
      ADDR_PD_MASK: read_reg = mask_q;
      ADDR_SYNC_REF: read_reg = syncref_q;
      ADDR_INPUT_TYPE: read_reg = intype_q;
      default: read_reg = RESET_BYTE;
    endcase
  endfunction

  // Serial port framing and shift
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    out_d = out_q;
    sdout_d = spi_sdout_q;
    wr_commit = 1'b0;
    // Fifteen bits in: read flag at 14, address at 13:7
    wr_addr = shift_q[13:7];
    wr_data = {shift_q[6:0], spi_sdata};
    if (spi_sen_n)
    begin
      state_d = SPI_IDLE;
      cnt_d = '0;
    end
    else
    begin
      unique case (state_q)
        SPI_IDLE:
        begin
          state_d = SPI_CMD;
          cnt_d = '0;
        end
        SPI_CMD:
          if (spi_sclk && !sclk_q)
          begin
            shift_d = {shift_q[14:0], spi_sdata};
            cnt_d = cnt_q + 5'h01;
            if (cnt_d == CMD_BITS)
            begin
              state_d = SPI_DATA;
              out_d = read_reg(shift_d[6:0]);
            end
          end
        SPI_DATA:
        begin
          if (!spi_sclk && sclk_q)
          begin
            sdout_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
          end
          if (spi_sclk && !sclk_q)
          begin
            shift_d = {shift_q[14:0], spi_sdata};
            cnt_d = cnt_q + 5'h01;
            if (cnt_d == FRAME_BITS)
            begin
              state_d = SPI_DONE;
              wr_commit = !shift_q[READ_FLAG_BIT + 7];
            end
          end
        end
        SPI_DONE: state_d = SPI_DONE;
      endcase
    end
  end

  // Register writes; reserved bits dropped
  always_comb
  begin
    drv0_d = drv0_q;
    drv1_d = drv1_q;
    drv2_d = drv2_q;
    mask_d = mask_q;
    syncref_d = syncref_q;
    intype_d = intype_q;
    if (wr_commit)
    begin
      unique case (wr_addr)
        ADDR_DRV_OFF_0: drv0_d = wr_data & WMASK_DRV_OFF;
        ADDR_DRV_OFF_1: drv1_d = wr_data & WMASK_DRV_OFF;
        ADDR_DRV_OFF_2: drv2_d = wr_data & WMASK_DRV_OFF;
        ADDR_PD_MASK: mask_d = wr_data & WMASK_PD_MASK;
        ADDR_SYNC_REF: syncref_d = wr_data & WMASK_SYNC_REF;
        ADDR_INPUT_TYPE: intype_d = wr_data & WMASK_INPUT_TYPE;
        default: ;
      endcase
    end
  end

  // Sync sources and global power down
  always_comb
  begin
    reg_sync_evt = wr_commit && (wr_addr == ADDR_SYNC_REF) && wr_data[REG_SYNC_BIT]
      && !syncref_q[REG_SYNC_BIT] && wr_data[REG_SYNC_ENABLE_BIT];
    // pin sync only without register source
    pin_sync_evt = sync_or_powerdown_pin && !pin_q && syncref_q[PIN_ROLE_SYNC_BIT]
      && !syncref_q[REG_SYNC_ENABLE_BIT];
    pin_pd = sync_or_powerdown_pin && !syncref_q[PIN_ROLE_SYNC_BIT];
    gpd = global_powerdown_request || pin_pd;
  end

  // Power, reference and wake state
  always_comb
  begin
    // field honoured only under register control
    if (syncref_q[REFERENCE_CONTROL_SOURCE_BIT])
    begin
      ref_d.ref_mode = (syncref_q[REF_SEL_MSB:REF_SEL_LSB] == REF_EXT_DIRECT)
        ? REF_EXT_DIRECT
        : (syncref_q[REF_SEL_MSB:REF_SEL_LSB] == REF_EXT_BUFFERED) ? REF_EXT_BUFFERED
        : REF_INTERNAL;
      ref_d.single_ended_clock = syncref_q[SINGLE_ENDED_CLOCK_SELECT_BIT];
    end
    else
    begin
      ref_d.ref_mode = reference_buffer_strap_pin ? REF_EXT_BUFFERED : REF_INTERNAL;
      ref_d.single_ended_clock = 1'b0;
    end
    // single ended powers down differential buffer
    power_d.clock_buffer_off = (gpd && !mask_q[KEEP_CLOCK_BUFFER_ON_BIT])
      || ref_d.single_ended_clock;
    power_d.ref_amp_off = gpd && !mask_q[KEEP_REFERENCE_AMP_ON_BIT];
    power_d.bandgap_off = gpd && mask_q[BANDGAP_OFF_IN_STANDBY_BIT];
    // longer wake when bandgap was off
    bg_was_off_d = gpd ? power_d.bandgap_off : bg_was_off_q;
    if (gpd)
      wake_d = power_d.bandgap_off ? WAKE_SLOW : WAKE_FAST;
    else if (wake_q != WAKE_ZERO)
      wake_d = wake_q - 1'b1;
    else
      wake_d = wake_q;
  end

  // Combined 24-bit driver view of the three registers
  assign drv_all = {drv2_q, drv1_q, drv0_q};

  // Register everything
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= SPI_IDLE;
      cnt_q <= '0;
      shift_q <= '0;
      out_q <= RESET_BYTE;
      sclk_q <= 1'b0;
      spi_sdout_q <= 1'b0;
      drv0_q <= RESET_BYTE;
      drv1_q <= RESET_BYTE;
      drv2_q <= RESET_BYTE;
      mask_q <= RESET_BYTE;
      syncref_q <= RESET_BYTE;
      intype_q <= RESET_BYTE;
      pin_q <= 1'b0;
      bg_was_off_q <= 1'b0;
      wake_q <= '0;
      output_driver_off_bits_q <= '0;
      frame_clock_output_off_q <= 1'b1;
      chan_a_bit1_off_q <= 1'b0;
      chan_a_bit6_off_q <= 1'b0;
      external_data_clock_input_on_q <= 1'b0;
      data_clock_output_off_q <= 1'b0;
      global_powerdown_q <= 1'b0;
      power_q <= '0;
      ref_q <= '0;
      chan_a_single_ended_input_q <= 1'b0;
      chan_b_single_ended_input_q <= 1'b0;
      sync_pulse_q <= 1'b0;
      analog_ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      out_q <= out_d;
      sclk_q <= spi_sclk;
      spi_sdout_q <= sdout_d;
      drv0_q <= drv0_d;
      drv1_q <= drv1_d;
      drv2_q <= drv2_d;
      mask_q <= mask_d;
      syncref_q <= syncref_d;
      intype_q <= intype_d;
      pin_q <= sync_or_powerdown_pin;
      bg_was_off_q <= bg_was_off_d;
      wake_q <= wake_d;
      output_driver_off_bits_q <= drv_all;
      // frame clock in serial, bit 1 in DDR
      frame_clock_output_off_q <= serial_mode ? drv_all[FRAME_OR_A1_BIT] : 1'b1;
      chan_a_bit1_off_q <= serial_mode ? 1'b1 : drv_all[FRAME_OR_A1_BIT];
      chan_a_bit6_off_q <= drv_all[CHAN_A_BIT6_BIT];
      external_data_clock_input_on_q <= external_data_clock_input_enable_a && external_data_clock_input_enable_b;
      data_clock_output_off_q <= data_clock_output_off_ctl;
      global_powerdown_q <= gpd;
      power_q <= power_d;
      ref_q <= ref_d;
      chan_a_single_ended_input_q <= intype_q[CHAN_A_SINGLE_ENDED_INPUT_BIT];
      chan_b_single_ended_input_q <= intype_q[CHAN_B_SINGLE_ENDED_INPUT_BIT];
      sync_pulse_q <= reg_sync_evt || pin_sync_evt;
      analog_ready_q <= !gpd && (wake_q == WAKE_ZERO);
    end
  end

  // Checks on driver, power, sync and reference behaviour
  property p_drv_write;
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_commit && wr_addr == ADDR_DRV_OFF_0) |-> ##2 output_driver_off_bits_q[7:0] == $past(wr_data, 2);
  endproperty
  a_drv_write: assert property (p_drv_write) else $error("driver off bits not applied");

  property p_a6_map;
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 chan_a_bit6_off_q == $past(drv2_q[CHAN_A_BIT6_BIT - 16]);
  endproperty
  a_a6_map: assert property (p_a6_map) else $error("channel A bit 6 map wrong");

  property p_external_data_clock_input;
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 external_data_clock_input_on_q == ($past(external_data_clock_input_enable_a) && $past(external_data_clock_input_enable_b));
  endproperty
  a_external_data_clock_input: assert property (p_external_data_clock_input) else $error("data clock input buffer wrong");

  property p_clk_mask;
    @(posedge ref_clk) disable iff (!reset_n)
    (gpd && !ref_d.single_ended_clock) |=> power_q.clock_buffer_off == !$past(mask_q[3]);
  endproperty
  a_clk_mask: assert property (p_clk_mask) else $error("clock buffer mask ignored");

  property p_amp_mask;
    @(posedge ref_clk) disable iff (!reset_n)
    global_powerdown_request |=> power_q.ref_amp_off == !$past(mask_q[2]);
  endproperty
  a_amp_mask: assert property (p_amp_mask) else $error("amp mask ignored");

  property p_bg_mask;
    @(posedge ref_clk) disable iff (!reset_n)
    global_powerdown_q |-> power_q.bandgap_off == $past(mask_q[1]);
  endproperty
  a_bg_mask: assert property (p_bg_mask) else $error("bandgap mask wrong");

  property p_slow_wake;
    @(posedge ref_clk) disable iff (!reset_n)
    ($fell(global_powerdown_q) && bg_was_off_q) |-> !analog_ready_q [*8];
  endproperty
  a_slow_wake: assert property (p_slow_wake) else $error("wake too quick");

  property p_pin_pd;
    @(posedge ref_clk) disable iff (!reset_n)
    (sync_or_powerdown_pin && !syncref_q[7]) |=> global_powerdown_q;
  endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("pin power down missed");

  property p_reg_sync;
    @(posedge ref_clk) disable iff (!reset_n)
    reg_sync_evt |=> sync_pulse_q ##1 !sync_pulse_q;
  endproperty
  a_reg_sync: assert property (p_reg_sync) else $error("register sync not issued");

  property p_pin_ignored;
    @(posedge ref_clk) disable iff (!reset_n)
    (syncref_q[5] && !reg_sync_evt) |=> !sync_pulse_q;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin sync under register source");

  property p_strap;
    @(posedge ref_clk) disable iff (!reset_n)
    !syncref_q[3] |=> !ref_q.single_ended_clock && ref_q.ref_mode != REF_EXT_DIRECT;
  endproperty
  a_strap: assert property (p_strap) else $error("register used under strap control");

  property p_reserved;
    @(posedge ref_clk) disable iff (!reset_n)
    (intype_q & ~WMASK_INPUT_TYPE) == 8'h00 && (mask_q & ~WMASK_PD_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit stored");

  property p_se_a;
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 chan_a_single_ended_input_q == $past(intype_q[5]);
  endproperty
  a_se_a: assert property (p_se_a) else $error("channel A input type wrong");

  c_reg_sync: cover property (@(posedge ref_clk) disable iff (!reset_n) reg_sync_evt ##1 sync_pulse_q);
  c_pin_pd: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(global_powerdown_q) ##[1:200] analog_ready_q);
  c_write: cover property (@(posedge ref_clk) disable iff (!reset_n) wr_commit && wr_addr == ADDR_SYNC_REF);
endmodule // adc_power_sync_ref_config

// ---- hw/cfg_pkg.sv ----
// Constants and types for the converter power, sync and reference configuration bank
package cfg_pkg;
  // Register addresses on the serial port
  localparam logic [6:0] ADDR_DRV_OFF_0 = 7'h0A;
  localparam logic [6:0] ADDR_DRV_OFF_1 = 7'h0B;
  localparam logic [6:0] ADDR_DRV_OFF_2 = 7'h0C;
  localparam logic [6:0] ADDR_PD_MASK = 7'h0D;
  localparam logic [6:0] ADDR_SYNC_REF = 7'h0E;
  localparam logic [6:0] ADDR_INPUT_TYPE = 7'h11;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Writable bits; reserved bits stay zero
  localparam logic [7:0] WMASK_DRV_OFF = 8'hFF;
  localparam logic [7:0] WMASK_PD_MASK = 8'h0E;
  localparam logic [7:0] WMASK_SYNC_REF = 8'hEF;
  localparam logic [7:0] WMASK_INPUT_TYPE = 8'h30;
  // Power down mask fields
  localparam int KEEP_CLOCK_BUFFER_ON_BIT = 3;
  localparam int KEEP_REFERENCE_AMP_ON_BIT = 2;
  localparam int BANDGAP_OFF_IN_STANDBY_BIT = 1;
  // Sync and reference fields
  localparam int PIN_ROLE_SYNC_BIT = 7;
  localparam int REG_SYNC_BIT = 6;
  localparam int REG_SYNC_ENABLE_BIT = 5;
  localparam int REFERENCE_CONTROL_SOURCE_BIT = 3;
  localparam int REF_SEL_MSB = 2;
  localparam int REF_SEL_LSB = 1;
  localparam int SINGLE_ENDED_CLOCK_SELECT_BIT = 0;
  // Input type fields
  localparam int CHAN_A_SINGLE_ENDED_INPUT_BIT = 5;
  localparam int CHAN_B_SINGLE_ENDED_INPUT_BIT = 4;
  // Driver bits with their own outputs within the 24-bit vector; bit 12 depends on mode
  localparam int FRAME_OR_A1_BIT = 12;
  localparam int CHAN_A_BIT6_BIT = 17;
  // Reference codes
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXT_BUFFERED = 2'h1;
  localparam logic [1:0] REF_EXT_DIRECT = 2'h2;
  // Serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int READ_FLAG_BIT = 7;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD = 2'b01,
    SPI_DATA = 2'b11,
    SPI_DONE = 2'b10
  } spi_state_t;

  typedef struct packed {
    logic clock_buffer_off;
    logic ref_amp_off;
    logic bandgap_off;
  } power_state_t;

  typedef struct packed {
    logic [1:0] ref_mode;
    logic single_ended_clock;
  } ref_cfg_t;
endpackage

// ---- tb/spi_host_model.sv ----
// Host serial controller model that frames register reads and writes
module spi_host_model
  import cfg_pkg::*;
(
  input wire logic ref_clk, // Bench clock
  output logic spi_sen_n, // Serial enable, active low
  output logic spi_sclk, // Serial clock, idle low
  output logic spi_sdata, // Serial data to the device
  input wire logic spi_sdout_q // Serial data from the device
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines at time zero
  initial
  begin
    spi_sen_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdata = 1'b0;
  end

  // One frame, MSB first; fewer than 16 bits aborts the frame
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    spi_sen_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 15; i > 15 - nbits; i--)
    begin
      spi_sdata <= frame[i];
      spi_sclk <= 1'b0;
      repeat (3) @(posedge ref_clk);
      spi_sclk <= 1'b1;
      if (i < 8)
        rd[i] = spi_sdout_q; // Read bit sampled on our rising clock
      repeat (3) @(posedge ref_clk);
    end
    spi_sclk <= 1'b0;
    repeat (3) @(posedge ref_clk);
    spi_sen_n <= 1'b1;
    spi_sdata <= ~spi_sdata; // Released line shows no stale value
    repeat (2) @(posedge ref_clk);
  endtask

  // Register write frame
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    xfer({1'b0, addr, data}, 16, unused);
  endtask

  // zero data field
  // Register read frame
  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    xfer({1'b1, addr, 8'h00}, 16, data);
  endtask
endmodule // spi_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the power, sync and reference configuration bank
module testbench
  import cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk, reset_n, spi_sen_n, spi_sclk, spi_sdata, spi_sdout_q;
  logic sync_or_powerdown_pin, reference_buffer_strap_pin, global_powerdown_request;
  logic serial_mode, external_data_clock_input_enable_a, external_data_clock_input_enable_b, data_clock_output_off_ctl;
  logic [23:0] output_driver_off_bits_q;
  logic frame_clock_output_off_q, chan_a_bit1_off_q, chan_a_bit6_off_q;
  logic external_data_clock_input_on_q, data_clock_output_off_q, global_powerdown_q;
  power_state_t power_q;
  ref_cfg_t ref_q;
  logic chan_a_single_ended_input_q, chan_b_single_ended_input_q, sync_pulse_q, analog_ready_q;
  int fails = 0;
  int tests_run = 0;
  int sync_count = 0;
  logic [6:0] addrs [6] = '{7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h11};
  logic [7:0] wmask [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h0E, 8'hEF, 8'h30};

  // Clock source
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  // Sync pulse tally
  always @(posedge ref_clk)
    if (sync_pulse_q === 1'b1)
      sync_count++;

  adc_power_sync_ref_config #(.WAKE_FAST_CYCLES(10), .WAKE_SLOW_CYCLES(20), .WAKE_W(8))
  adc_power_sync_ref_config_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .spi_sen_n(spi_sen_n), .spi_sclk(spi_sclk), .spi_sdata(spi_sdata),
    .spi_sdout_q(spi_sdout_q), .sync_or_powerdown_pin(sync_or_powerdown_pin),
    .reference_buffer_strap_pin(reference_buffer_strap_pin),
    .global_powerdown_request(global_powerdown_request), .serial_mode(serial_mode),
    .external_data_clock_input_enable_a(external_data_clock_input_enable_a), .external_data_clock_input_enable_b(external_data_clock_input_enable_b),
    .data_clock_output_off_ctl(data_clock_output_off_ctl),
    .output_driver_off_bits_q(output_driver_off_bits_q),
    .frame_clock_output_off_q(frame_clock_output_off_q),
    .chan_a_bit1_off_q(chan_a_bit1_off_q), .chan_a_bit6_off_q(chan_a_bit6_off_q),
    .external_data_clock_input_on_q(external_data_clock_input_on_q),
    .data_clock_output_off_q(data_clock_output_off_q),
    .global_powerdown_q(global_powerdown_q), .power_q(power_q), .ref_q(ref_q),
    .chan_a_single_ended_input_q(chan_a_single_ended_input_q),
    .chan_b_single_ended_input_q(chan_b_single_ended_input_q),
    .sync_pulse_q(sync_pulse_q), .analog_ready_q(analog_ready_q));

  spi_host_model spi_host_model_inst (.ref_clk(ref_clk), .spi_sen_n(spi_sen_n),
    .spi_sclk(spi_sclk), .spi_sdata(spi_sdata), .spi_sdout_q(spi_sdout_q));

  // Verdict and end of run
  task automatic stop_test();
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare with four-state equality
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Register write and read-back helpers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi_host_model_inst.write_reg(a, d);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    spi_host_model_inst.read_reg(a, v);
    chk(v, exp, what);
  endtask

  // Bounded wait for the analog wake indication
  task automatic wait_ready(output int n);
    n = 0;
    while (analog_ready_q !== 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300)
    begin
      fails++;
      $display("FAIL %0t wake wait ran out", $time);
      stop_test();
    end
  endtask

  // Run-length guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    $display("FAIL %0t run too long", $time);
    stop_test();
  end

  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic [2:0] m;
    int n;
    int s0;
    reset_n = 1'b0;
    sync_or_powerdown_pin = 1'b0;
    reference_buffer_strap_pin = 1'b0;
    global_powerdown_request = 1'b0;
    serial_mode = 1'b0;
    external_data_clock_input_enable_a = 1'b0;
    external_data_clock_input_enable_b = 1'b0;
    data_clock_output_off_ctl = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(frame_clock_output_off_q, 1, "frame off at reset");
    for (int i = 0; i < 6; i++)
    begin
      rchk(addrs[i], 8'h00, "reset value");
      wr(addrs[i], 8'hFF);
      rchk(addrs[i], wmask[i], "writable bits");
      wr(addrs[i], 8'h00);
    end
    wr(7'h0F, 8'hFF);
    rchk(7'h0F, 8'h00, "unmapped read");
    spi_host_model_inst.xfer({1'b0, ADDR_DRV_OFF_0, 8'hA5}, 12, v);
    rchk(ADDR_DRV_OFF_0, 8'h00, "aborted frame");
    // DDR driver settings
    wr(ADDR_DRV_OFF_0, 8'h23);
    wr(ADDR_DRV_OFF_1, 8'h46);
    wr(ADDR_DRV_OFF_2, 8'hF0);
    repeat (2) @(posedge ref_clk);
    chk(output_driver_off_bits_q, 24'hF04623, "ddr drivers");
    chk({frame_clock_output_off_q, chan_a_bit1_off_q, chan_a_bit6_off_q}, 3'b100, "ddr map");
    // Serial driver settings, frame clock on the shared bit, channel A bit 1 forced off
    serial_mode <= 1'b1;
    wr(ADDR_DRV_OFF_0, 8'h7F);
    wr(ADDR_DRV_OFF_1, 8'hEE);
    wr(ADDR_DRV_OFF_2, 8'hFC);
    repeat (2) @(posedge ref_clk);
    chk(output_driver_off_bits_q, 24'hFCEE7F, "serial drivers");
    chk({frame_clock_output_off_q, chan_a_bit1_off_q, chan_a_bit6_off_q}, 3'b010, "serial map");
    wr(ADDR_DRV_OFF_1, 8'h10);
    wr(ADDR_DRV_OFF_2, 8'h02);
    repeat (2) @(posedge ref_clk);
    chk({frame_clock_output_off_q, chan_a_bit1_off_q, chan_a_bit6_off_q}, 3'b111, "serial set");
    // Data clock buffers follow outside controls only
    for (int k = 0; k < 8; k++)
    begin
      m = k[2:0];
      external_data_clock_input_enable_a <= m[2];
      external_data_clock_input_enable_b <= m[1];
      data_clock_output_off_ctl <= m[0];
      repeat (3) @(posedge ref_clk);
      chk({external_data_clock_input_on_q, data_clock_output_off_q}, {m[2] & m[1], m[0]}, "data_clock_output");
    end
    // Global power down under every mask, with wake timing
    for (int k = 0; k < 8; k++)
    begin
      m = k[2:0];
      wr(ADDR_PD_MASK, {4'h0, m, 1'b0});
      global_powerdown_request <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(global_powerdown_q, 1, "request power down");
      chk(power_q, {~m[2], ~m[1], m[0]}, "masked blocks");
      global_powerdown_request <= 1'b0;
      wait_ready(n);
      s0 = m[0] ? 20 : 10;
      chk(n >= s0 && n <= s0 + 4, 1, "wake time");
    end
    // Pin role: power down, then sync
    sync_or_powerdown_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(global_powerdown_q, 1, "pin power down");
    sync_or_powerdown_pin <= 1'b0;
    wait_ready(n);
    wr(ADDR_SYNC_REF, 8'h80);
    s0 = sync_count;
    sync_or_powerdown_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({global_powerdown_q, 8'(sync_count - s0)}, 9'h001, "pin sync");
    sync_or_powerdown_pin <= 1'b0;
    wr(ADDR_SYNC_REF, 8'hA0);
    s0 = sync_count;
    sync_or_powerdown_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(sync_count - s0, 0, "pin sync with register source");
    sync_or_powerdown_pin <= 1'b0;
    // Register sync: once per rise, only when enabled
    wr(ADDR_SYNC_REF, 8'h00);
    s0 = sync_count;
    wr(ADDR_SYNC_REF, 8'h60);
    chk(sync_count - s0, 1, "register sync");
    wr(ADDR_SYNC_REF, 8'h60);
    wr(ADDR_SYNC_REF, 8'h20);
    chk(sync_count - s0, 1, "no repeat sync");
    wr(ADDR_SYNC_REF, 8'h40);
    chk(sync_count - s0, 1, "sync disabled");
    // Reference from strap, then from register codes
    wr(ADDR_SYNC_REF, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk(ref_q, 3'b000, "strap low");
    reference_buffer_strap_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(ref_q, 3'b010, "strap high");
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_SYNC_REF, {4'h0, 1'b1, c[1:0], 1'b0});
      repeat (2) @(posedge ref_clk);
      chk(ref_q, (c == 3) ? 3'b000 : {c[1:0], 1'b0}, "reference code");
    end
    wr(ADDR_SYNC_REF, 8'h09);
    repeat (2) @(posedge ref_clk);
    chk({ref_q.single_ended_clock, power_q.clock_buffer_off}, 2'b11, "single clock");
    // Analog input type
    for (int k = 1; k < 4; k++)
    begin
      m = k[2:0];
      wr(ADDR_INPUT_TYPE, {2'b00, m[1:0], 4'h0});
      repeat (2) @(posedge ref_clk);
      chk({chan_a_single_ended_input_q, chan_b_single_ended_input_q}, m[1:0], "input type");
    end
    stop_test();
  end
endmodule // testbench
